// ==== rtl/frc_ctrl.sv ====
`timescale 1ns/1ps
module frc_ctrl (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] cmd_code_in,
	input  wire logic       wr_en_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       rd_en_in,
	output logic      [7:0] rd_data_out,
	output logic            rd_valid_out,
	input  wire logic       clear_faults_in,
	input  wire logic       clear_status_in,
	input  wire logic       unit_tick_in,
	input  wire logic       fault_in,
	input  wire logic       on_in,
	input  wire logic       fault_reset_in,
	input  wire logic       other_fault_in,
	output logic            output_en_out,
	output logic            fault_status_out,
	output logic            latched_out
);
	import frc_pkg::*;

	function automatic logic [7:0] delay_units(input logic [2:0] n);
		delay_units = 8'h01 << n;
	endfunction

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [7:0] resp_r;
	logic [7:0] timer_r;
	logic [7:0] timer_nxt;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	frc_state_t state_r;
	frc_state_t state_nxt;
	logic       timer_clr;

	wire        fault_s      = sync2_r[0];
	wire        on_s         = sync2_r[1];
	wire        freset_s     = sync2_r[2];
	wire        other_s      = sync2_r[3];
	wire  [1:0] mode         = resp_r[RESP_MSB:RESP_LSB];
	wire  [2:0] retry        = resp_r[RETRY_MSB:RETRY_LSB];
	wire  [2:0] dly          = resp_r[DELAY_MSB:DELAY_LSB];
	wire  [7:0] units        = delay_units(dly);
	wire        expire       = unit_tick_in && (timer_r == units - 8'h01);
	wire        hit_reg      = (cmd_code_in == CMD_UT_FAULT_RESP);
	wire        clr          = clear_faults_in | clear_status_in | freset_s;
	wire  [2:0] cnt_inc      = cnt_r + 3'h1;
	wire        retry_none   = (retry == RETRY_NONE);
	wire        out_on_nxt   = (state_nxt == ST_RUN) ||
	                           (state_nxt == ST_DELAY);

	// pins pass two flops first
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else begin
			sync1_r <= {other_fault_in, fault_reset_in, on_in, fault_in};
			sync2_r <= sync1_r;
		end
	end

	// byte register access
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			resp_r       <= RESP_RST;
			rd_data_out  <= 8'h00;
			rd_valid_out <= 1'b0;
		end else begin
			if (wr_en_in && hit_reg) begin
				resp_r <= wr_data_in;
			end
			rd_valid_out <= rd_en_in;
			if (rd_en_in) begin
				rd_data_out <= hit_reg ? resp_r : 8'h00;
			end
		end
	end

	// response sequencer
	always_comb begin
		state_nxt = state_r;
		timer_clr = 1'b0;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_OFF: begin
				cnt_nxt = CNT_RST;
				if (on_s) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (fault_s) begin
					case (mode)
						MODE_IGNORE: state_nxt = ST_RUN;
						MODE_DELAY: begin
							state_nxt = ST_DELAY;
							timer_clr = 1'b1;
						end
						MODE_DISABLE: begin
							timer_clr = 1'b1;
							state_nxt = retry_none ? ST_LATCH : ST_WAIT;
						end
						default: state_nxt = ST_LATCH;
					endcase
				end
			end
			ST_DELAY: begin
				if (!fault_s) begin
					state_nxt = ST_RUN;
				end else if (expire) begin
					timer_clr = 1'b1;
					state_nxt = retry_none ? ST_LATCH : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (other_s) begin
					state_nxt = ST_LATCH;
				end else if (clr) begin
					state_nxt = ST_RUN;
					cnt_nxt   = CNT_RST;
				end else if (expire) begin
					timer_clr = 1'b1;
					if (!fault_s) begin
						state_nxt = ST_RUN;
						cnt_nxt   = CNT_RST;
					end else if (retry != RETRY_FOREVER &&
					             cnt_inc == retry) begin
						state_nxt = ST_LATCH;
					end else begin
						cnt_nxt = (retry == RETRY_FOREVER) ? cnt_r
						                                   : cnt_inc;
					end
				end
			end
			ST_LATCH: begin
				if (clr) begin
					state_nxt = ST_RUN;
					cnt_nxt   = CNT_RST;
				end
			end
			default: state_nxt = ST_OFF;
		endcase
		if (!on_s) begin
			state_nxt = ST_OFF;
		end
	end

	assign timer_nxt = timer_clr ? TIMER_RST :
	                   (unit_tick_in ? timer_r + 8'h01 : timer_r);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_r          <= ST_OFF;
			timer_r          <= TIMER_RST;
			cnt_r            <= CNT_RST;
			output_en_out    <= 1'b0;
			latched_out      <= 1'b0;
			fault_status_out <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			timer_r       <= timer_nxt;
			cnt_r         <= cnt_nxt;
			output_en_out <= out_on_nxt;
			latched_out   <= (state_nxt == ST_LATCH);
			// set wins over clear
			if (fault_s && state_r != ST_OFF) begin
				fault_status_out <= 1'b1;
			end else if (clr) begin
				fault_status_out <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	AST_IGNORE: assert property (
		state_r == ST_RUN && mode == MODE_IGNORE && on_s
		|=> output_en_out && state_r == ST_RUN)
		else $error("ignore mode dropped the output");
	AST_DELAY_RUNS: assert property (
		state_r == ST_DELAY |-> output_en_out)
		else $error("output off during run delay");
	AST_DISABLE_NOW: assert property (
		state_r == ST_RUN && fault_s && mode == MODE_DISABLE && on_s
		|=> !output_en_out)
		else $error("disable mode left output on");
	AST_LATCH_HOLD: assert property (
		state_r == ST_LATCH && !clr && on_s
		|=> state_r == ST_LATCH && !output_en_out)
		else $error("latched fault released");
	AST_CLEAR: assert property (
		state_r == ST_LATCH && clear_faults_in && on_s
		|=> state_r == ST_RUN ##1 output_en_out || state_r != ST_RUN)
		else $error("clear did not release latch");
	AST_NO_RETRY: assert property (
		state_r == ST_DELAY && fault_s && expire && retry_none && on_s
		|=> latched_out && !output_en_out)
		else $error("retry none did not latch");
	AST_RETRY_LIMIT: assert property (
		state_r == ST_WAIT && expire && fault_s && on_s && !other_s &&
		!clr && retry != RETRY_FOREVER && cnt_inc == retry
		|=> state_r == ST_LATCH)
		else $error("retry limit not enforced");
	AST_INTERVAL: assert property (
		state_r == ST_WAIT && expire && fault_s && state_nxt == ST_WAIT
		|=> timer_r == TIMER_RST && state_r == ST_WAIT)
		else $error("retry interval not restarted");
	AST_FOREVER: assert property (
		state_r == ST_WAIT && retry == RETRY_FOREVER && fault_s &&
		on_s && !other_s && !clr |=> state_r == ST_WAIT)
		else $error("unlimited retry stopped");
	AST_UNIT_ONE: assert property (
		state_r == ST_WAIT && dly == 3'h0 && unit_tick_in |-> expire)
		else $error("delay zero is not one unit");
	AST_UNIT_POW: assert property (
		dly == 3'h7 && timer_r == 8'h7f && unit_tick_in |-> expire)
		else $error("delay seven is not 128 units");
	AST_REG_READ: assert property (
		rd_en_in && hit_reg |=> rd_valid_out && rd_data_out == $past(resp_r))
		else $error("register read mismatch");
	AST_CNT_CLR: assert property (
		state_r == ST_LATCH && clr && on_s |=> cnt_r == CNT_RST)
		else $error("attempt counter not cleared");

	COV_DELAY: cover property (state_r == ST_DELAY ##1 state_r == ST_WAIT);
	COV_LATCH: cover property (state_r == ST_WAIT ##1 state_r == ST_LATCH);
	COV_RECOVER: cover property (state_r == ST_WAIT ##1 state_r == ST_RUN);
endmodule

// ==== rtl/frc_pkg.sv ====
// Function
// - response 00: output keeps running despite fault
// - response 01: run for delay, then retry
// - response 10: disable at once, then retry setting
// - response 11: stay off until fault cleared
// - clear by status, command, reset, off-on
// - retry 000: no restart, off until cleared
// - retry 1..6: that many attempts, then latch
// - attempt start spacing equals programmed delay
// - retry 111: retry until off or other fault
// - delay field 0 means one unit
// - delay field n means 2**n units
// - settings byte at command 0x54, read/write
package frc_pkg;
	localparam logic [7:0] CMD_UT_FAULT_RESP = 8'h54;
	localparam logic [7:0] RESP_RST          = 8'h00;
	localparam int         RESP_MSB          = 7;
	localparam int         RESP_LSB          = 6;
	localparam int         RETRY_MSB         = 5;
	localparam int         RETRY_LSB         = 3;
	localparam int         DELAY_MSB         = 2;
	localparam int         DELAY_LSB         = 0;
	localparam logic [1:0] MODE_IGNORE       = 2'h0;
	localparam logic [1:0] MODE_DELAY        = 2'h1;
	localparam logic [1:0] MODE_DISABLE      = 2'h2;
	localparam logic [1:0] MODE_LATCH        = 2'h3;
	localparam logic [2:0] RETRY_NONE        = 3'h0;
	localparam logic [2:0] RETRY_FOREVER     = 3'h7;
	localparam logic [7:0] TIMER_RST         = 8'h00;
	localparam logic [2:0] CNT_RST           = 3'h0;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_DELAY,
		ST_WAIT,
		ST_LATCH
	} frc_state_t;
endpackage

// ==== sim/frc_host.sv ====
`timescale 1ns/1ps
module frc_host (
	input  wire logic       clk_in,
	output logic      [7:0] cmd_out,
	output logic            wr_out,
	output logic      [7:0] wd_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in
);
	initial begin
		{cmd_out, wd_out, wr_out, rd_out} = 18'h0_0000;
	end
	// one byte write, strobe held for one sampling edge
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		cmd_out <= c;
		wd_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		@(posedge clk_in);
	endtask
	// one byte read, data only counts while valid is up
	task automatic rd(input logic [7:0] c, output logic [7:0] d);
		cmd_out <= c;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1 d = rvalid_in ? rdata_in : 8'hxx;
		@(posedge clk_in);
	endtask
endmodule

// ==== sim/frc_ctrl_bench.sv ====
`timescale 1ns/1ps
module fault_response_retry_ctrl_bench;
	import frc_pkg::*;
	logic       clk, rst, cf, cs, tk, flt, on, frst, oth;
	logic       wr, rd, rv, oe, st, lat;
	logic [7:0] cmd, wd, rdat, v;
	int         num_errors = 0;
	int         total_checks = 0;
	frc_host host (.clk_in(clk), .cmd_out(cmd), .wr_out(wr), .wd_out(wd),
		.rd_out(rd), .rdata_in(rdat), .rvalid_in(rv));
	frc_ctrl dut (.sys_clk_in(clk), .rst_in(rst), .cmd_code_in(cmd),
		.wr_en_in(wr), .wr_data_in(wd), .rd_en_in(rd), .rd_data_out(rdat),
		.rd_valid_out(rv), .clear_faults_in(cf), .clear_status_in(cs),
		.unit_tick_in(tk), .fault_in(flt), .on_in(on), .fault_reset_in(frst),
		.other_fault_in(oth), .output_en_out(oe), .fault_status_out(st),
		.latched_out(lat));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick;
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		cyc(2);
		#1;
	endtask
	// program the response, raise the fault, land after the third edge
	task automatic go(input logic [7:0] cfg);
		host.wr(CMD_UT_FAULT_RESP, cfg);
		flt <= 1'b1;
		cyc(2);
		#1 chk(oe, 1'b1);
		@(posedge clk);
		#1 chk(st, 1'b1);
	endtask
	// fault gone, then one clearing method, output must come back
	task automatic clr(input int m);
		flt <= 1'b0;
		cyc(3);
		cs <= (m == 0);
		cf <= (m == 1);
		frst <= (m == 2);
		on <= (m != 3);
		@(posedge clk);
		cs <= 1'b0;
		cf <= 1'b0;
		cyc(3);
		frst <= 1'b0;
		on <= 1'b1;
		cyc(6);
		#1 chk(oe, 1'b1);
		if (m != 3) chk(st, 1'b0);
	endtask
	task automatic t_reg;
		host.rd(CMD_UT_FAULT_RESP, v);
		chk(v, RESP_RST);
		host.wr(8'h53, 8'hff);
		host.rd(CMD_UT_FAULT_RESP, v);
		chk(v, RESP_RST);
		host.wr(CMD_UT_FAULT_RESP, 8'ha5);
		host.rd(CMD_UT_FAULT_RESP, v);
		chk(v, 8'ha5);
		host.rd(8'h53, v);
		chk(v, 8'h00);
	endtask
	task automatic t_ignore;
		go({MODE_IGNORE, 6'h3f});
		repeat (3) tick();
		chk(oe, 1'b1);
		clr(1);
	endtask
	task automatic t_latch;
		for (int m = 0; m < 4; m++) begin
			go({MODE_LATCH, 6'h09});
			chk(oe, 1'b0);
			repeat (3) tick();
			chk(oe, 1'b0);
			chk(lat, 1'b1);
			clr(m);
		end
	endtask
	task automatic t_retry;
		for (int k = 0; k < 7; k++) begin
			go({MODE_DISABLE, 3'(k), 3'h1});
			chk(oe, 1'b0);
			if (k == 0) begin
				repeat (4) tick();
			end else begin
				repeat (2 * k - 1) tick();
				chk(lat, 1'b0);
				tick();
				chk(lat, 1'b1);
			end
			chk(oe, 1'b0);
			clr(1);
		end
	endtask
	task automatic t_delay;
		for (int n = 0; n < 3; n++) begin
			go({MODE_DELAY, 3'h0, 3'(n)});
			repeat ((1 << n) - 1) tick();
			chk(oe, 1'b1);
			tick();
			chk(oe, 1'b0);
			clr(1);
		end
	endtask
	task automatic t_forever;
		go({MODE_DISABLE, RETRY_FOREVER, 3'h0});
		repeat (10) tick();
		chk(lat, 1'b0);
		oth <= 1'b1;
		cyc(4);
		#1 chk(lat, 1'b1);
		oth <= 1'b0;
		clr(1);
		go({MODE_DISABLE, 6'h10});
		tick();
		flt <= 1'b0;
		cyc(3);
		tick();
		chk(oe, 1'b1);
		flt <= 1'b1;
		cyc(3);
		tick();
		chk(lat, 1'b0);
		clr(1);
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		{cf, cs, tk, flt, on, frst, oth} = 7'h00;
		rst = 1'b1;
		cyc(2);
		rst <= 1'b0;
		t_reg();
		on <= 1'b1;
		cyc(5);
		#1 chk(oe, 1'b1);
		chk(st, 1'b0);
		t_ignore();
		t_latch();
		t_retry();
		t_delay();
		t_forever();
		give_verdict();
	end
endmodule
